//--- rtl/fppio_pkg.sv
package fppio_pkg;
   // register indexes; some printed offsets are not word aligned,
   // so each register sits alone in lane 0 at byte address four times its index
   localparam logic [7:0] ADDR_PORT_A_LATCH     = 8'h00;
   localparam logic [7:0] ADDR_PORT_B_LATCH     = 8'h01;
   localparam logic [7:0] ADDR_PORT_C_LATCH     = 8'h02;
   localparam logic [7:0] ADDR_PORT_D_LATCH     = 8'h03;
   localparam logic [7:0] ADDR_PORT_A_DIRECTION = 8'h04;
   localparam logic [7:0] ADDR_PORT_B_DIRECTION = 8'h05;
   localparam logic [7:0] ADDR_PORT_C_DIRECTION = 8'h06;
   localparam logic [7:0] ADDR_PORT_D_DIRECTION = 8'h07;
   localparam logic [7:0] ADDR_PORT_E_LATCH     = 8'h08;
   localparam logic [7:0] ADDR_PORT_E_DIRECTION = 8'h0C;
   localparam logic [7:0] ADDR_PORT_A_PULLUP    = 8'h0D;
   localparam logic [7:0] ADDR_PORT_C_PULLUP    = 8'h0E;
   localparam logic [7:0] ADDR_PORT_D_PULLUP    = 8'h0F;
   // implemented bits per port
   localparam int WIDTH_A = 4;
   localparam int WIDTH_B = 6;
   localparam int WIDTH_C = 2;
   localparam int WIDTH_D = 7;
   localparam int WIDTH_E = 2;
   localparam int PIN_COUNT = 21;
   // reset values and htrans codes
   localparam logic [7:0] DIRECTION_RESET = 8'h00;
   localparam logic [7:0] PULLUP_RESET    = 8'h00;
   localparam logic [1:0] HTRANS_NONSEQ   = 2'b10;
   localparam logic [1:0] HTRANS_SEQ      = 2'b11;
endpackage

//--- rtl/fppio_pin.sv
`timescale 1ns/10ps
`default_nettype none
module fppio_pin #(
   parameter int W  = 8,
   parameter bit PU = 1'b0
) (
   // register state
   input  wire logic [W-1:0] latch,
   input  wire logic [W-1:0] direction,
   input  wire logic [W-1:0] pullup_enable,
   // pins
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_out,
   output logic      [W-1:0] pin_oe_n,
   output logic      [W-1:0] pin_pullup,
   // read view
   output logic      [W-1:0] read_value
);
   assign pin_out    = latch;
   assign pin_oe_n   = ~direction;                              // [R2] [R10]
   // pullup only while input, dropped automatically on output
   assign pin_pullup = PU ? (pullup_enable & ~direction) : '0;  // [R3] [R4]
   assign read_value = (direction & latch) | (~direction & pin_in); // [R11]
endmodule
`default_nettype wire

//--- rtl/fppio_ahb.sv
`timescale 1ns/10ps
`default_nettype none
module fppio_ahb
   import fppio_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb slave side
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   // decoded data phase
   output logic             wr_phase,
   output logic [7:0]       wr_index
);
   logic       wr_pend_reg;
   logic [7:0] wr_addr_reg;
   // writes land in the data phase, when hwdata is valid
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
      end else if (hready) begin
         wr_pend_reg <= hsel & hwrite & (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
         wr_addr_reg <= haddr[9:2];
      end
   end
   assign wr_phase = wr_pend_reg;
   assign wr_index = wr_addr_reg;
endmodule
`default_nettype wire

//--- rtl/fppio_top.sv
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// R1: twenty-one bidirectional pins in ports A to E, each with latch and direction bit
// R2: each pin individually selectable as input or output by its direction bit
// R3: only ports A, C, D have per-bit pullups, active only as inputs
// R4: pullup forced off while direction is output, restored on return to input
// R5: software should make unbonded pins outputs to avoid floating inputs
// R6: port A pullup register holds bits 3..0, upper zero, reset zero
// R7: port C pullup register holds bits 1..0, rest zero, reset zero
// R8: port D pullup register holds bits 6..0, bit 7 zero, reset zero
// R9: port D direction holds bits 6..0, bit 7 zero, reset makes inputs
// R10: direction one enables output driver, zero makes pin an input
// R11: data read gives latch for outputs, pin level for inputs; writes hit latch
// R12: data latches keep contents through reset; direction registers clear
// R13: unimplemented bits read zero and ignore writes
module fppio_top
   import fppio_pkg::*;
(
   // clock and reset
   input  wire logic                  hclk,
   input  wire logic                  hresetn,
   // ahb-lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic                  hready,
   input  wire logic [31:0]           hwdata,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // port a pins
   input  wire logic [fppio_pkg::WIDTH_A-1:0] port_a_in,
   output logic      [fppio_pkg::WIDTH_A-1:0] port_a_out,
   output logic      [fppio_pkg::WIDTH_A-1:0] port_a_oe_n,
   output logic      [fppio_pkg::WIDTH_A-1:0] port_a_pullup,
   // port b pins
   input  wire logic [fppio_pkg::WIDTH_B-1:0] port_b_in,
   output logic      [fppio_pkg::WIDTH_B-1:0] port_b_out,
   output logic      [fppio_pkg::WIDTH_B-1:0] port_b_oe_n,
   // port c pins
   input  wire logic [fppio_pkg::WIDTH_C-1:0] port_c_in,
   output logic      [fppio_pkg::WIDTH_C-1:0] port_c_out,
   output logic      [fppio_pkg::WIDTH_C-1:0] port_c_oe_n,
   output logic      [fppio_pkg::WIDTH_C-1:0] port_c_pullup,
   // port d pins
   input  wire logic [fppio_pkg::WIDTH_D-1:0] port_d_in,
   output logic      [fppio_pkg::WIDTH_D-1:0] port_d_out,
   output logic      [fppio_pkg::WIDTH_D-1:0] port_d_oe_n,
   output logic      [fppio_pkg::WIDTH_D-1:0] port_d_pullup,
   // port e pins
   input  wire logic [fppio_pkg::WIDTH_E-1:0] port_e_in,
   output logic      [fppio_pkg::WIDTH_E-1:0] port_e_out,
   output logic      [fppio_pkg::WIDTH_E-1:0] port_e_oe_n
);
   import fppio_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register state
   // latches: no reset at all, contents survive a system reset [R12]
   logic [WIDTH_A-1:0] lat_a_reg;
   logic [WIDTH_B-1:0] lat_b_reg;
   logic [WIDTH_C-1:0] lat_c_reg;
   logic [WIDTH_D-1:0] lat_d_reg;
   logic [WIDTH_E-1:0] lat_e_reg;
   logic [WIDTH_A-1:0] dir_a_reg;
   logic [WIDTH_B-1:0] dir_b_reg;
   logic [WIDTH_C-1:0] dir_c_reg;
   logic [WIDTH_D-1:0] dir_d_reg;
   logic [WIDTH_E-1:0] dir_e_reg;
   logic [WIDTH_A-1:0] pue_a_reg;
   logic [WIDTH_C-1:0] pue_c_reg;
   logic [WIDTH_D-1:0] pue_d_reg;

   logic       wr_phase;
   logic [7:0] wr_index;
   logic [7:0] wbyte;
   logic [7:0] rd_next;
   logic [7:0] rd_reg;
   logic [WIDTH_A-1:0] rv_a;
   logic [WIDTH_B-1:0] rv_b;
   logic [WIDTH_C-1:0] rv_c;
   logic [WIDTH_D-1:0] rv_d;
   logic [WIDTH_E-1:0] rv_e;

   // true when register index idx equals register index a
   function automatic logic hit(input logic [7:0] idx, input logic [7:0] a);
      hit = (idx == a);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // bus slave
   fppio_ahb u_ahb (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .hsel     (hsel),
      .haddr    (haddr),
      .htrans   (htrans),
      .hwrite   (hwrite),
      .hready   (hready),
      .wr_phase (wr_phase),
      .wr_index (wr_index)
   );
   // zero wait states, always okay; hsize unused since only words are issued
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign wbyte     = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // data latches, writes always go to the latch [R11] [R12]
   always_ff @(posedge hclk) begin
      if (wr_phase && hit(wr_index, ADDR_PORT_A_LATCH))
         lat_a_reg <= hwdata[WIDTH_A-1:0];                          // [R13]
      if (wr_phase && hit(wr_index, ADDR_PORT_B_LATCH))
         lat_b_reg <= hwdata[WIDTH_B-1:0];
      if (wr_phase && hit(wr_index, ADDR_PORT_C_LATCH))
         lat_c_reg <= hwdata[WIDTH_C-1:0];
      if (wr_phase && hit(wr_index, ADDR_PORT_D_LATCH))
         lat_d_reg <= hwdata[WIDTH_D-1:0];
      if (wr_phase && hit(wr_index, ADDR_PORT_E_LATCH))
         lat_e_reg <= hwdata[WIDTH_E-1:0];
   end

   ////////////////////////////////////////////////////////////////////////////
   // direction registers, cleared so every pin comes up an input [R9] [R12]
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_a_reg <= DIRECTION_RESET[WIDTH_A-1:0];
         dir_b_reg <= DIRECTION_RESET[WIDTH_B-1:0];
         dir_c_reg <= DIRECTION_RESET[WIDTH_C-1:0];
         dir_d_reg <= DIRECTION_RESET[WIDTH_D-1:0];                   // [R9]
         dir_e_reg <= DIRECTION_RESET[WIDTH_E-1:0];
      end else begin
         if (wr_phase && hit(wr_index, ADDR_PORT_A_DIRECTION))
            dir_a_reg <= hwdata[WIDTH_A-1:0];                       // [R2]
         if (wr_phase && hit(wr_index, ADDR_PORT_B_DIRECTION))
            dir_b_reg <= hwdata[WIDTH_B-1:0];
         if (wr_phase && hit(wr_index, ADDR_PORT_C_DIRECTION))
            dir_c_reg <= hwdata[WIDTH_C-1:0];
         if (wr_phase && hit(wr_index, ADDR_PORT_D_DIRECTION))
            dir_d_reg <= hwdata[WIDTH_D-1:0];                       // [R9]
         if (wr_phase && hit(wr_index, ADDR_PORT_E_DIRECTION))
            dir_e_reg <= hwdata[WIDTH_E-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pullup enables, ports a, c, d only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pue_a_reg <= PULLUP_RESET[WIDTH_A-1:0];                     // [R6]
         pue_c_reg <= PULLUP_RESET[WIDTH_C-1:0];                     // [R7]
         pue_d_reg <= PULLUP_RESET[WIDTH_D-1:0];                     // [R8]
      end else begin
         if (wr_phase && hit(wr_index, ADDR_PORT_A_PULLUP))
            pue_a_reg <= hwdata[WIDTH_A-1:0];                       // [R6]
         if (wr_phase && hit(wr_index, ADDR_PORT_C_PULLUP))
            pue_c_reg <= hwdata[WIDTH_C-1:0];                       // [R7]
         if (wr_phase && hit(wr_index, ADDR_PORT_D_PULLUP))
            pue_d_reg <= hwdata[WIDTH_D-1:0];                       // [R8]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin logic, one instance per port [R1]
   fppio_pin #(.W(WIDTH_A), .PU(1'b1)) u_pa (
      .latch         (lat_a_reg),
      .direction     (dir_a_reg),
      .pullup_enable (pue_a_reg),
      .pin_in        (port_a_in),
      .pin_out       (port_a_out),
      .pin_oe_n      (port_a_oe_n),
      .pin_pullup    (port_a_pullup),
      .read_value    (rv_a)
   );
   fppio_pin #(.W(WIDTH_B), .PU(1'b0)) u_pb (
      .latch         (lat_b_reg),
      .direction     (dir_b_reg),
      .pullup_enable ('0),
      .pin_in        (port_b_in),
      .pin_out       (port_b_out),
      .pin_oe_n      (port_b_oe_n),
      .pin_pullup    (),
      .read_value    (rv_b)
   );
   fppio_pin #(.W(WIDTH_C), .PU(1'b1)) u_pc (
      .latch         (lat_c_reg),
      .direction     (dir_c_reg),
      .pullup_enable (pue_c_reg),
      .pin_in        (port_c_in),
      .pin_out       (port_c_out),
      .pin_oe_n      (port_c_oe_n),
      .pin_pullup    (port_c_pullup),
      .read_value    (rv_c)
   );
   fppio_pin #(.W(WIDTH_D), .PU(1'b1)) u_pd (
      .latch         (lat_d_reg),
      .direction     (dir_d_reg),
      .pullup_enable (pue_d_reg),
      .pin_in        (port_d_in),
      .pin_out       (port_d_out),
      .pin_oe_n      (port_d_oe_n),
      .pin_pullup    (port_d_pullup),
      .read_value    (rv_d)
   );
   fppio_pin #(.W(WIDTH_E), .PU(1'b0)) u_pe (
      .latch         (lat_e_reg),
      .direction     (dir_e_reg),
      .pullup_enable ('0),
      .pin_in        (port_e_in),
      .pin_out       (port_e_out),
      .pin_oe_n      (port_e_oe_n),
      .pin_pullup    (),
      .read_value    (rv_e)
   );

   ////////////////////////////////////////////////////////////////////////////
   // read mux, sampled at the address phase; missing bits read zero [R13]
   always_comb begin
      rd_next = 8'h00;
      case (haddr[9:2])
         ADDR_PORT_A_LATCH:     rd_next = 8'(rv_a);                  // [R11]
         ADDR_PORT_B_LATCH:     rd_next = 8'(rv_b);
         ADDR_PORT_C_LATCH:     rd_next = 8'(rv_c);
         ADDR_PORT_D_LATCH:     rd_next = 8'(rv_d);
         ADDR_PORT_E_LATCH:     rd_next = 8'(rv_e);
         ADDR_PORT_A_DIRECTION: rd_next = 8'(dir_a_reg);
         ADDR_PORT_B_DIRECTION: rd_next = 8'(dir_b_reg);
         ADDR_PORT_C_DIRECTION: rd_next = 8'(dir_c_reg);
         ADDR_PORT_D_DIRECTION: rd_next = 8'(dir_d_reg);             // [R9]
         ADDR_PORT_E_DIRECTION: rd_next = 8'(dir_e_reg);
         ADDR_PORT_A_PULLUP:    rd_next = 8'(pue_a_reg);             // [R6]
         ADDR_PORT_C_PULLUP:    rd_next = 8'(pue_c_reg);             // [R7]
         ADDR_PORT_D_PULLUP:    rd_next = 8'(pue_d_reg);             // [R8]
         default:               rd_next = wbyte;
      endcase
   end

   // one register per word, so every access is an aligned word
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_reg <= 8'h00;
      end else if (hready && hsel && !hwrite && htrans[1]) begin
         rd_reg <= rd_next;
      end
   end
   // register byte in lane 0; upper lanes always zero [R13]
   assign hrdata = {24'h000000, rd_reg};

   // unbonded pins should be set as outputs by software [R5]
endmodule
`default_nettype wire

//--- test/fppio_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module fppio_pin_model #(
   parameter int W = 8
) (
   // device side
   input  wire logic [W-1:0] drv,
   input  wire logic [W-1:0] oe_n,
   input  wire logic [W-1:0] pu,
   // outside world
   input  wire logic [W-1:0] ext,
   input  wire logic [W-1:0] flt,
   // level at the pin
   output logic      [W-1:0] lvl
);
   // a floating line without pull shows the inverse latch, never a stale level
   always_comb lvl = (~oe_n & drv) | (oe_n & ~flt & ext) | (oe_n & flt & (pu | ~drv));
endmodule
`default_nettype wire

//--- test/fppio_top_props.sv
`timescale 1ns/10ps
`default_nettype none
module fppio_top_props
   import fppio_pkg::*;
(
   // clock and reset
   input  wire logic               hclk,
   input  wire logic               hresetn,
   // bus
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic               hready,
   input  wire logic [31:0]        hwdata,
   input  wire logic [31:0]        hrdata,
   // pins
   input  wire logic [WIDTH_A-1:0] port_a_in,
   input  wire logic [WIDTH_A-1:0] port_a_out,
   input  wire logic [WIDTH_A-1:0] port_a_oe_n,
   input  wire logic [WIDTH_A-1:0] port_a_pullup,
   input  wire logic [WIDTH_C-1:0] port_c_oe_n,
   input  wire logic [WIDTH_C-1:0] port_c_pullup,
   input  wire logic [WIDTH_D-1:0] port_d_out,
   input  wire logic [WIDTH_D-1:0] port_d_oe_n,
   input  wire logic [WIDTH_D-1:0] port_d_pullup
);
   logic       w_ph;
   logic       r_ph;
   logic [7:0] p_addr;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         w_ph <= 1'b0;
         r_ph <= 1'b0;
      end else begin
         w_ph <= hsel & hready & htrans[1] & hwrite;
         r_ph <= hsel & hready & htrans[1] & ~hwrite;
      end
   end
   always_ff @(posedge hclk) begin
      if (hsel & hready & htrans[1]) begin
         p_addr <= haddr[9:2];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////
   property p_dir_a;
      w_ph && p_addr == ADDR_PORT_A_DIRECTION |=> port_a_oe_n == ~$past(hwdata[3:0]);
   endproperty
   a_dir_a: assert property (p_dir_a) else $error("port a drive wrong");
   property p_dir_d;
      w_ph && p_addr == ADDR_PORT_D_DIRECTION |=> port_d_oe_n == ~$past(hwdata[6:0]);
   endproperty
   a_dir_d: assert property (p_dir_d) else $error("port d drive wrong");
   property p_pu_a;
      w_ph && p_addr == ADDR_PORT_A_PULLUP |=> port_a_pullup == ($past(hwdata[3:0]) & port_a_oe_n);
   endproperty
   a_pu_a: assert property (p_pu_a) else $error("port a pullup wrong");
   property p_pu_c;
      w_ph && p_addr == ADDR_PORT_C_PULLUP |=> port_c_pullup == ($past(hwdata[1:0]) & port_c_oe_n);
   endproperty
   a_pu_c: assert property (p_pu_c) else $error("port c pullup wrong");
   property p_pu_d;
      w_ph && p_addr == ADDR_PORT_D_PULLUP |=> port_d_pullup == ($past(hwdata[6:0]) & port_d_oe_n);
   endproperty
   a_pu_d: assert property (p_pu_d) else $error("port d pullup wrong");
   property p_pu_off;
      ((port_a_pullup & ~port_a_oe_n) == 4'h0) && ((port_d_pullup & ~port_d_oe_n) == 7'h00);
   endproperty
   a_pu_off: assert property (p_pu_off) else $error("pullup on an output");
   property p_out;
      w_ph && p_addr == ADDR_PORT_A_LATCH |=> port_a_out == $past(hwdata[3:0]);
   endproperty
   a_out: assert property (p_out) else $error("latch write lost");
   property p_out_d;
      w_ph && p_addr == ADDR_PORT_D_LATCH |=> port_d_out == $past(hwdata[6:0]);
   endproperty
   a_out_d: assert property (p_out_d) else $error("port d latch write lost");
   property p_rd_out;
      r_ph && p_addr == 8'h00 && $past(port_a_oe_n) == 4'h0 |-> hrdata[3:0] == $past(port_a_out);
   endproperty
   a_rd_out: assert property (p_rd_out) else $error("output read not latch");
   property p_rd_in;
      r_ph && p_addr == 8'h00 && $past(port_a_oe_n) == 4'hF |-> hrdata[3:0] == $past(port_a_in);
   endproperty
   a_rd_in: assert property (p_rd_in) else $error("input read not pin");
   property p_rd_zero;
      r_ph && p_addr == 8'h09 |-> hrdata == 32'h0;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("unmapped read not zero");
   property p_reset;
      $rose(hresetn) |-> (&port_a_oe_n) && (&port_d_oe_n) && port_d_pullup == 7'h00;
   endproperty
   a_reset: assert property (p_reset) else $error("reset left a driver on");
   c_unmapped: cover property (r_ph && p_addr == 8'h09);
   c_pullup: cover property (w_ph && p_addr == ADDR_PORT_A_PULLUP);
   c_reset: cover property ($rose(hresetn));
endmodule
bind fppio_top fppio_top_props fppio_top_props_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hwdata(hwdata), .hrdata(hrdata), .port_a_in(port_a_in), .port_a_out(port_a_out),
   .port_a_oe_n(port_a_oe_n), .port_a_pullup(port_a_pullup), .port_c_oe_n(port_c_oe_n),
   .port_c_pullup(port_c_pullup), .port_d_out(port_d_out), .port_d_oe_n(port_d_oe_n),
   .port_d_pullup(port_d_pullup));
`default_nettype wire

//--- test/fppio_bench.sv
`timescale 1ns/10ps
`default_nettype none
module fppio_bench;
   import fppio_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, junk;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   wire logic   hready;
   logic [3:0]  a_out, a_oen, a_pu, a_in, a_ext, a_flt;
   logic [5:0]  b_out, b_oen, b_in, b_ext;
   logic [1:0]  c_out, c_oen, c_pu, c_in, c_ext, e_out, e_oen, e_in, e_ext;
   logic [6:0]  d_out, d_oen, d_pu, d_in, d_ext, flt_bcde;
   logic [7:0]  adr [8];
   logic [7:0]  val [8];
   int          n_fail, cmp_count, cyc;
   assign hready = hreadyout;
   fppio_top fppio_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .port_a_in(a_in), .port_a_out(a_out), .port_a_oe_n(a_oen), .port_a_pullup(a_pu),
      .port_b_in(b_in), .port_b_out(b_out), .port_b_oe_n(b_oen),
      .port_c_in(c_in), .port_c_out(c_out), .port_c_oe_n(c_oen), .port_c_pullup(c_pu),
      .port_d_in(d_in), .port_d_out(d_out), .port_d_oe_n(d_oen), .port_d_pullup(d_pu),
      .port_e_in(e_in), .port_e_out(e_out), .port_e_oe_n(e_oen));
   fppio_pin_model #(.W(4)) pa_i (.drv(a_out), .oe_n(a_oen), .pu(a_pu), .ext(a_ext),
      .flt(a_flt), .lvl(a_in));
   fppio_pin_model #(.W(6)) pb_i (.drv(b_out), .oe_n(b_oen), .pu(6'h00), .ext(b_ext),
      .flt(flt_bcde[5:0]), .lvl(b_in));
   fppio_pin_model #(.W(2)) pc_i (.drv(c_out), .oe_n(c_oen), .pu(c_pu), .ext(c_ext),
      .flt(flt_bcde[1:0]), .lvl(c_in));
   fppio_pin_model #(.W(7)) pd_i (.drv(d_out), .oe_n(d_oen), .pu(d_pu), .ext(d_ext),
      .flt(flt_bcde), .lvl(d_in));
   fppio_pin_model #(.W(2)) pe_i (.drv(e_out), .oe_n(e_oen), .pu(2'h0), .ext(e_ext),
      .flt(flt_bcde[1:0]), .lvl(e_in));
   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 3000) begin
         n_fail++;
         conclude();
      end
   end
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {22'h0, a, 2'b00};
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task rchk(input string what, input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      check(what, q, {24'h0, exp});
   endtask
   task t_regs(input logic [63:0] wv, input logic [63:0] exp);
      for (int i = 0; i < 8; i++) xfer(1'b1, adr[i], {24'h0, wv[8*i+:8]}, junk);
      for (int i = 0; i < 8; i++) rchk("register", adr[i], exp[8*i+:8]);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      adr = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
      {hresetn, hsel, hwrite, htrans, haddr, hwdata, hsize, flt_bcde} = '0;
      {a_ext, a_flt, b_ext, c_ext, d_ext, e_ext} = {4'h5, 4'h0, 6'h2A, 2'h2, 7'h55, 2'h1};
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      hsize <= 3'b010;
      check("pins", 32'($bits(a_in) + $bits(b_in) + $bits(c_in) + $bits(d_in) + $bits(e_in)), 32'd21);
      for (int i = 0; i < 8; i++) rchk("reset value", adr[i], 8'h00);
      check("drive after reset", 32'({a_oen, b_oen, c_oen, d_oen, e_oen}), 32'h1FFFFF);
      $display("test reset done");
      t_regs(64'hFFFFFFFFFFFFFFFF, 64'h7F030F037F033F0F);
      check("all drive", 32'({a_oen, b_oen, c_oen, d_oen, e_oen}), 32'h0);
      check("pullups on outputs", 32'({a_pu, c_pu, d_pu}), 32'h0);
      t_regs(64'hFFFFFF0000000005, 64'h7F030F0000000005);
      check("pullups restored", 32'({a_pu, c_pu, d_pu}), 32'h15FF);
      $display("test widths done");
      xfer(1'b1, 8'h04, 32'h0, junk);
      a_flt <= 4'hF;
      rchk("pulled pin", 8'h00, 8'h0F);
      rchk("pin b", 8'h01, 8'h2A);
      val = '{8'h03, 8'h15, 8'h01, 8'h2A, 8'h0, 8'h0, 8'h0, 8'h0};
      for (int i = 0; i < 4; i++) xfer(1'b1, 8'(i), {24'h0, val[i]}, junk);
      rchk("input after write", 8'h00, 8'h0F);
      // unbonded port b pins are made outputs along with ports a, c and d
      for (int i = 0; i < 4; i++) xfer(1'b1, adr[i], 32'hFF, junk);
      for (int i = 0; i < 4; i++) rchk("output latch", 8'(i), val[i]);
      xfer(1'b1, 8'h08, 32'hFFFFFFFF, junk);
      xfer(1'b1, 8'h0C, 32'h7F030F03, junk);
      rchk("latch e", 8'h08, 8'h03);
      rchk("unmapped", 8'h09, 8'h00);
      check("pin outputs", 32'({a_out, d_out, e_out}), 32'h06AB);
      $display("test data done");
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      rchk("dir after reset", 8'h07, 8'h00);
      check("drive cleared", 32'({a_oen, d_oen}), 32'h7FF);
      xfer(1'b1, 8'h04, 32'hFFFFFFFF, junk);
      xfer(1'b1, 8'h07, 32'hFFFFFFFF, junk);
      rchk("latch kept a", 8'h00, 8'h03);
      rchk("latch kept d", 8'h03, 8'h2A);
      $display("test keep done");
      conclude();
   end
endmodule
`default_nettype wire
